// ==== src/epo_cfg.svh ====
// constants for the energy pulse output stage: offsets, fields, resets, timing
`ifndef EPO_CFG_SVH
`define EPO_CFG_SVH

// system clock
`define EPO_CLK_PERIOD_NS      10
`define EPO_CLK_HZ             100000000

// register byte addresses
`define EPO_ADDR_CTRL          8'h00
`define EPO_ADDR_STATUS        8'h04
`define EPO_ADDR_LF_COUNT      8'h08

// control field positions and reset value
`define EPO_CTRL_FS_LOW_BIT    0
`define EPO_CTRL_FS_HIGH_BIT   1
`define EPO_CTRL_SCALE_BIT     2
`define EPO_CTRL_WIDTH         3
`define EPO_CTRL_RESET         3'h0

// status field positions
`define EPO_STAT_REV_BIT       0
`define EPO_STAT_NOLOAD_BIT    1
`define EPO_STAT_PULSE_A_BIT   2
`define EPO_STAT_PULSE_B_BIT   3
`define EPO_STAT_CAL_BIT       4

// low-frequency outputs: width is half the period limit
`define EPO_LF_PERIOD_LIMIT_MS 240
`define EPO_LF_WIDTH_CYC       ((`EPO_LF_PERIOD_LIMIT_MS / 2) * 1000000 / `EPO_CLK_PERIOD_NS)

// calibration output: normal width and high-frequency mode width
`define EPO_CF_PERIOD_LIMIT_MS 180
`define EPO_CF_WIDTH_MS        90
`define EPO_CF_WIDTH_CYC       (`EPO_CF_WIDTH_MS * 1000000 / `EPO_CLK_PERIOD_NS)
`define EPO_HF_WIDTH_NS        35000
`define EPO_HF_WIDTH_CYC       (`EPO_HF_WIDTH_NS / `EPO_CLK_PERIOD_NS)

// base frequency: oscillator over 2^16 for the fastest selection
`define EPO_OSC_HZ             450000
`define EPO_BASE_DIV           65536
`define EPO_BASE_CYC           ((64'd`EPO_BASE_DIV * 64'd`EPO_CLK_HZ) / 64'd`EPO_OSC_HZ)

// no-load: minimum rate of 0.00244 % of base, as parts per billion of full scale;
// rounded up so a sample that still falls short of the minimum rate counts as no-load
`define EPO_MIN_FREQ_PPB       24400
`define EPO_MAG_FULL           64'h800000
`define EPO_PPB_ONE            64'd1000000000
`define EPO_NOLOAD_LEVEL \
  ((`EPO_MAG_FULL * 64'd`EPO_MIN_FREQ_PPB + `EPO_PPB_ONE - 64'd1) / `EPO_PPB_ONE)

`endif

// ==== src/epo_pkg.sv ====
// types and shared arithmetic of the energy pulse output stage
package epo_pkg;

  // software-steered mode selection
  typedef struct packed {
    logic cal_scale;
    logic fs_high;
    logic fs_low;
  } epo_ctrl_t;

  // accumulator step result
  typedef struct packed {
    logic [51:0] acc;
    logic        fire;
  } epo_acc_t;

  typedef enum logic [1:0] {
    EPO_RESP_OKAY   = 2'h0,
    EPO_RESP_SLVERR = 2'h2
  } epo_resp_t;

  // one accumulation step; hold freezes the sum under no-load
  function automatic epo_acc_t epo_accumulate(input logic [51:0] acc,
                                              input logic [23:0] add,
                                              input logic [51:0] thresh,
                                              input logic        hold);
    epo_acc_t   r;
    logic [51:0] sum;
    sum    = acc + 52'(add);
    r.acc  = acc;
    r.fire = 1'b0;
    if (!hold) begin
      if (sum >= thresh) begin
        r.acc  = sum - thresh;
        r.fire = 1'b1;
      end else begin
        r.acc  = sum;
      end
    end
    return r;
  endfunction

  // log2 of calibration-to-low-frequency rate ratio
  function automatic logic [3:0] epo_cf_shift(input epo_ctrl_t c);
    logic [3:0] s;
    unique case ({c.cal_scale, c.fs_high, c.fs_low})
      3'h4:    s = 4'h7;
      3'h0:    s = 4'h6;
      3'h5:    s = 4'h6;
      3'h1:    s = 4'h5;
      3'h6:    s = 4'h5;
      3'h2:    s = 4'h4;
      3'h7:    s = 4'h4;
      default: s = 4'hB;
    endcase
    return s;
  endfunction

endpackage

// ==== src/epo_pulse_timer.sv ====
// one pulse shaper: fixed width, shortened to half the measured period
`timescale 1ns/100ps
module epo_pulse_timer (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        fire,
  input  wire logic [31:0] width_cap,
  input  wire logic        fixed_only,
  output logic             pulse
);
  import epo_pkg::*;

  localparam logic [31:0] SAT = 32'hFFFFFFFF;

  logic [31:0] since_q, since_d;
  logic [31:0] cnt_q, cnt_d;
  logic        pulse_q, pulse_d;
  logic [31:0] period;
  logic [31:0] width;

  // width chosen from the last period; first pulse after reset sees a saturated period
  always_comb begin
    period = (since_q == SAT) ? SAT : since_q + 32'h1;
    if (fixed_only || (period >> 1) >= width_cap) begin
      width = width_cap;
    end else begin
      width = period >> 1;
    end
    if (width == 32'h0) begin
      width = 32'h1;
    end
    since_d = fire ? 32'h0 : period;
    cnt_d   = cnt_q;
    pulse_d = pulse_q;
    if (fire) begin
      cnt_d   = width - 32'h1;
      pulse_d = 1'b1;
    end else if (pulse_q && cnt_q != 32'h0) begin
      cnt_d   = cnt_q - 32'h1;
    end else begin
      pulse_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      since_q <= SAT;
      cnt_q   <= 32'h0;
      pulse_q <= 1'b0;
    end else begin
      since_q <= since_d;
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule // epo_pulse_timer

// ==== src/epo_pulse_stage.sv ====
// energy pulse output stage with its register slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "epo_cfg.svh"

module epo_pulse_stage #(
  parameter int unsigned     LF_WIDTH_CYC = `EPO_LF_WIDTH_CYC,
  parameter int unsigned     CF_WIDTH_CYC = `EPO_CF_WIDTH_CYC,
  parameter longint unsigned BASE_CYC     = `EPO_BASE_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic signed [23:0] power_in,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [7:0]         s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    energy_pulse_a,
  output logic                    energy_pulse_b,
  output logic                    calibration_pulse,
  output logic                    reverse_power_flag
);
  import epo_pkg::*;

  localparam int unsigned HF_WIDTH_CYC = `EPO_HF_WIDTH_CYC;
  localparam logic [23:0] NOLOAD_LEVEL = 24'(`EPO_NOLOAD_LEVEL);

  // power magnitude and sign; -2^23 still fits unsigned in 24 bits
  logic        sign_neg;
  logic [23:0] mag;
  assign sign_neg = power_in[23];
  assign mag      = power_in[23] ? 24'(-power_in) : 24'(power_in);

  // ---- control and accumulation state
  epo_ctrl_t   ctrl_q, ctrl_d;
  logic [51:0] lf_acc_q, lf_acc_d, cf_acc_q, cf_acc_d;
  logic        no_load_q, no_load_d;
  logic        side_q, side_d;
  logic        rev_q, rev_d;
  logic [31:0] lf_count_q, lf_count_d;
  logic        out_a_q, out_a_d, out_b_q, out_b_d, cal_q, cal_d;
  logic [1:0]  lf_shift;
  logic [51:0] lf_thresh, cf_thresh;
  logic        hf_mode;
  epo_acc_t    lf_step, cf_step;
  logic        lf_fire, cf_fire, lf_pulse, cf_pulse;

  // ---- bus slave state
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]  waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        commit;
  logic [31:0] status_word;

  // threshold per selection: slower base means a larger energy quantum
  always_comb begin
    lf_shift  = ~{ctrl_q.fs_high, ctrl_q.fs_low};
    lf_thresh = 52'(BASE_CYC << (7'd23 + 7'(lf_shift)));
    cf_thresh = lf_thresh >> epo_cf_shift(ctrl_q);
    hf_mode   = !ctrl_q.cal_scale && ctrl_q.fs_high && ctrl_q.fs_low;
    lf_step   = epo_accumulate(lf_acc_q, mag, lf_thresh, no_load_q);
    cf_step   = epo_accumulate(cf_acc_q, mag, cf_thresh, no_load_q);
    lf_fire   = lf_step.fire;
    cf_fire   = cf_step.fire;
  end

  // low-frequency shaper shared by both outputs, they never overlap
  epo_pulse_timer u_lf_timer (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .fire       (lf_fire),
    .width_cap  (LF_WIDTH_CYC),
    .fixed_only (1'b0),
    .pulse      (lf_pulse)
  );

  // calibration shaper; high-frequency mode skips the half-period rule
  epo_pulse_timer u_cf_timer (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .fire       (cf_fire),
    .width_cap  (hf_mode ? HF_WIDTH_CYC : CF_WIDTH_CYC),
    .fixed_only (hf_mode),
    .pulse      (cf_pulse)
  );

  // next state of the pulse logic
  always_comb begin
    lf_acc_d   = lf_step.acc;
    cf_acc_d   = cf_step.acc;
    no_load_d  = mag < NOLOAD_LEVEL;
    side_d     = lf_fire ? ~side_q : side_q;
    rev_d      = cf_fire ? sign_neg : rev_q;
    lf_count_d = lf_fire ? lf_count_q + 32'h1 : lf_count_q;
    out_a_d    = lf_pulse && side_q;
    out_b_d    = lf_pulse && !side_q;
    cal_d      = no_load_q || cf_pulse;
    ctrl_d     = ctrl_q;
    if (commit && waddr_q == `EPO_ADDR_CTRL && wstrb0_q) begin
      ctrl_d = epo_ctrl_t'(wdata_q[`EPO_CTRL_WIDTH-1:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q     <= epo_ctrl_t'(`EPO_CTRL_RESET);
      lf_acc_q   <= 52'h0;
      cf_acc_q   <= 52'h0;
      no_load_q  <= 1'b0;
      side_q     <= 1'b0;
      rev_q      <= 1'b0;
      lf_count_q <= 32'h0;
      out_a_q    <= 1'b0;
      out_b_q    <= 1'b0;
      cal_q      <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      lf_acc_q   <= lf_acc_d;
      cf_acc_q   <= cf_acc_d;
      no_load_q  <= no_load_d;
      side_q     <= side_d;
      rev_q      <= rev_d;
      lf_count_q <= lf_count_d;
      out_a_q    <= out_a_d;
      out_b_q    <= out_b_d;
      cal_q      <= cal_d;
    end
  end

  assign energy_pulse_a     = out_a_q;
  assign energy_pulse_b     = out_b_q;
  assign calibration_pulse  = cal_q;
  assign reverse_power_flag = rev_q;

  // status word for reads
  always_comb begin
    status_word = 32'h0;
    status_word[`EPO_STAT_REV_BIT]     = rev_q;
    status_word[`EPO_STAT_NOLOAD_BIT]  = no_load_q;
    status_word[`EPO_STAT_PULSE_A_BIT] = out_a_q;
    status_word[`EPO_STAT_PULSE_B_BIT] = out_b_q;
    status_word[`EPO_STAT_CAL_BIT]     = cal_q;
  end

  // bus slave: address and data latched in either order, one write in flight
  always_comb begin
    commit   = aw_got_q && w_got_q && !bvalid_q;
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      waddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d  = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (commit) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      // read-only words accept writes silently
      unique case (waddr_q)
        `EPO_ADDR_CTRL, `EPO_ADDR_STATUS, `EPO_ADDR_LF_COUNT: bresp_d = EPO_RESP_OKAY;
        default: bresp_d = EPO_RESP_SLVERR;
      endcase
    end
    awready_d = !aw_got_d;
    wready_d  = !w_got_d;
    // read side: one read at a time, data registered
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = EPO_RESP_OKAY;
      unique case (s_axi_araddr)
        `EPO_ADDR_CTRL:     rdata_d = {29'h0, ctrl_q};
        `EPO_ADDR_STATUS:   rdata_d = status_word;
        `EPO_ADDR_LF_COUNT: rdata_d = lf_count_q;
        default: begin
          rdata_d = 32'h0;
          rresp_d = EPO_RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb0_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ---- checking helpers: run lengths of output highs, last energy side
  logic [31:0] lf_hi_q, cf_hi_q, cf_norm_hi_q;
  logic        last_a_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lf_hi_q      <= 32'h0;
      cf_hi_q      <= 32'h0;
      cf_norm_hi_q <= 32'h0;
      last_a_q     <= 1'b0;
    end else begin
      // each output timed on its own: a direct hand-over from a to b is two pulses
      lf_hi_q      <= ((energy_pulse_a && $past(energy_pulse_a)) ||
                       (energy_pulse_b && $past(energy_pulse_b))) ? lf_hi_q + 32'h1 :
                      {31'h0, energy_pulse_a || energy_pulse_b};
      cf_hi_q      <= (no_load_q || !calibration_pulse) ? 32'h0 : cf_hi_q + 32'h1;
      // a long high-frequency pulse may run on briefly after that mode is left
      cf_norm_hi_q <= (no_load_q || !calibration_pulse || hf_mode) ? 32'h0 :
                      cf_norm_hi_q + 32'h1;
      last_a_q     <= (energy_pulse_a && !$past(energy_pulse_a)) ? 1'b1 :
                      (energy_pulse_b && !$past(energy_pulse_b)) ? 1'b0 : last_a_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_alt_a_first: assert property ($rose(energy_pulse_a) |-> !last_a_q && !energy_pulse_b)
    else $error("energy pulse a did not alternate");
  chk_alt_b_after: assert property ($rose(energy_pulse_b) |-> last_a_q && !energy_pulse_a)
    else $error("energy pulse b did not alternate");
  chk_lf_width_cap: assert property (lf_hi_q <= LF_WIDTH_CYC)
    else $error("energy pulse longer than fixed width");
  chk_cf_width_cap: assert property (!hf_mode |-> cf_norm_hi_q <= CF_WIDTH_CYC + 1)
    else $error("calibration pulse longer than its width");
  chk_hf_width: assert property (hf_mode && $stable(hf_mode) |-> cf_hi_q <= HF_WIDTH_CYC + 1)
    else $error("high-frequency calibration pulse too long");
  chk_noload_level: assert property ((mag < NOLOAD_LEVEL) |=> no_load_q)
    else $error("no-load not flagged below minimum level");
  chk_noload_lf: assert property (no_load_q |-> !lf_fire ##1 !$rose(lf_pulse))
    else $error("energy pulse issued under no-load");
  chk_noload_cf: assert property (no_load_q |=> calibration_pulse)
    else $error("calibration output not held high under no-load");
  chk_reverse_power_flag_sign: assert property (cf_fire |=> reverse_power_flag == $past(sign_neg))
    else $error("reverse flag does not match power sign");
  chk_reverse_power_flag_hold: assert property (!cf_fire |=> $stable(reverse_power_flag))
    else $error("reverse flag moved without a calibration pulse");

  cov_pulse_b: cover property ($rose(energy_pulse_b));
  cov_noload:  cover property ($rose(no_load_q));
  cov_hf_cal:  cover property (hf_mode && $rose(calibration_pulse));
  cov_reverse_power_flag:    cover property ($rose(reverse_power_flag));

endmodule // epo_pulse_stage

// ==== verification/epo_meter_model.sv ====
// far-side pulse counter model: counts, widths, phase order and rate ratio
`timescale 1ns/100ps
module epo_meter_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        energy_pulse_a,
  input  wire logic        energy_pulse_b,
  input  wire logic        calibration_pulse,
  output logic      [15:0] lf_count,
  output logic      [15:0] cal_count,
  output logic      [15:0] alt_errors,
  output logic      [15:0] lf_width,
  output logic      [15:0] cal_width,
  output logic      [15:0] cal_per_lf
);
  typedef struct packed {
    logic [15:0] lf_n, cal_n, alt, lf_w, cal_w, ratio, lf_run, cal_run, since;
    logic        a_p, b_p, c_p, want_b;
  } epo_meter_t;

  epo_meter_t st_q, st_d;
  logic       lf_any;

  assign lf_any = energy_pulse_a | energy_pulse_b;

  // observer next state; a stepper loses a step if one phase repeats
  always_comb begin
    st_d = st_q;
    if (lf_any) begin
      st_d.lf_run = st_q.lf_run + 16'h1;
    end else if (st_q.a_p | st_q.b_p) begin
      st_d.lf_w   = st_q.lf_run;
      st_d.lf_run = 16'h0;
    end
    if ((energy_pulse_a && !st_q.a_p) || (energy_pulse_b && !st_q.b_p)) begin
      if (energy_pulse_b != st_q.want_b) begin
        st_d.alt = st_q.alt + 16'h1;
      end
      st_d.want_b = energy_pulse_a;
      st_d.lf_n   = st_q.lf_n + 16'h1;
      st_d.ratio  = st_q.since;
      st_d.since  = 16'h0;
    end
    if (calibration_pulse) begin
      st_d.cal_run = st_q.cal_run + 16'h1;
    end else if (st_q.c_p) begin
      st_d.cal_w   = st_q.cal_run;
      st_d.cal_run = 16'h0;
    end
    // counted after the energy edge so coincident edges land in the next interval
    if (calibration_pulse && !st_q.c_p) begin
      st_d.since = st_d.since + 16'h1;
      st_d.cal_n = st_q.cal_n + 16'h1;
    end
    st_d.a_p = energy_pulse_a;
    st_d.b_p = energy_pulse_b;
    st_d.c_p = calibration_pulse;
  end

  // observer state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lf_count   = st_q.lf_n;
  assign cal_count  = st_q.cal_n;
  assign alt_errors = st_q.alt;
  assign lf_width   = st_q.lf_w;
  assign cal_width  = st_q.cal_w;
  assign cal_per_lf = st_q.ratio;
endmodule // epo_meter_model

// ==== verification/epo_pulse_stage_bench.sv ====
// self-checking bench for the energy pulse output stage
`timescale 1ns/100ps
`include "epo_cfg.svh"
module epo_pulse_stage_bench;
  import epo_pkg::*;
  localparam int unsigned LF_W = 20;
  localparam int unsigned CF_W = 15;
  localparam logic [2:0]  CODES [7] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h7};
  localparam int          SH    [7] = '{7, 6, 6, 5, 5, 4, 4};

  logic               sys_clk  = 1'h0;
  logic               sys_rst  = 1'h1;
  logic signed [23:0] power_in = 24'sh0;
  logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic               arvalid = 1'h0, rready = 1'h0;
  logic        [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        [31:0] wdata = 32'h0;
  logic        [3:0]  wstrb = 4'h0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic        [1:0]  bresp, rresp;
  logic        [31:0] rdata, rd;
  logic               pa, pb, cal, rev;
  logic        [15:0] lf_n, cal_n, alt_n, lf_w, cal_w, ratio;
  int                 err_count = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  int                 n0;

  always #5 sys_clk = ~sys_clk;

  epo_pulse_stage #(.LF_WIDTH_CYC(LF_W), .CF_WIDTH_CYC(CF_W), .BASE_CYC(1)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .power_in(power_in),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .energy_pulse_a(pa), .energy_pulse_b(pb), .calibration_pulse(cal),
    .reverse_power_flag(rev));

  epo_meter_model meter (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .energy_pulse_a(pa), .energy_pulse_b(pb),
    .calibration_pulse(cal), .lf_count(lf_n), .cal_count(cal_n), .alt_errors(alt_n),
    .lf_width(lf_w), .cal_width(cal_w), .cal_per_lf(ratio));

  task automatic stop_test;
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t response got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, ad, wd, tb;
    logic [1:0] r;
    @(posedge sys_clk);
    awvalid <= 1'h1; awaddr <= a; wvalid <= 1'h1; wdata <= d; wstrb <= s; bready <= 1'h1;
    ad = 1'h0; wd = 1'h0; tb = 1'h0;
    while (!(ad && wd)) begin
      @(negedge sys_clk); ta = awready & !ad; tw = wready & !wd;
      @(posedge sys_clk);
      if (ta) begin awvalid <= 1'h0; ad = 1'h1; end
      if (tw) begin wvalid <= 1'h0; wd = 1'h1; end
    end
    while (!tb) begin
      @(negedge sys_clk); tb = bvalid; r = bresp;
      @(posedge sys_clk);
    end
    bready <= 1'h0;
    check_resp(r, er);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
    logic t;
    logic [1:0] r;
    @(posedge sys_clk);
    arvalid <= 1'h1; araddr <= a; rready <= 1'h1; t = 1'h0;
    while (!t) begin @(negedge sys_clk); t = arready; @(posedge sys_clk); end
    arvalid <= 1'h0; t = 1'h0;
    while (!t) begin @(negedge sys_clk); t = rvalid; rd = rdata; r = rresp; @(posedge sys_clk); end
    rready <= 1'h0;
    check_resp(r, er);
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rd_reg(a, er);
    check_word(rd, ed, "register data");
  endtask

  task automatic set_ctrl(input logic [2:0] c);
    wr(`EPO_ADDR_CTRL, {29'h0, c}, 4'hF, EPO_RESP_OKAY);
  endtask

  task automatic set_pw(input logic signed [23:0] p);
    @(posedge sys_clk); power_in <= p;
  endtask

  task automatic wait_lf(input int n);
    n0 = int'(lf_n) + n;
    while (int'(lf_n) < n0) @(negedge sys_clk);
  endtask

  task automatic wait_cal(input int n);
    n0 = int'(cal_n) + n;
    while (int'(cal_n) < n0) @(negedge sys_clk);
  endtask

  // hang guard sized well above the longest sequence
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    reg_chk(`EPO_ADDR_CTRL, 32'h0, EPO_RESP_OKAY);
    wr(`EPO_ADDR_CTRL, 32'hFFFFFFFF, 4'hF, EPO_RESP_OKAY);
    reg_chk(`EPO_ADDR_CTRL, 32'h7, EPO_RESP_OKAY);
    wr(`EPO_ADDR_CTRL, 32'h0, 4'h0, EPO_RESP_OKAY);
    reg_chk(`EPO_ADDR_CTRL, 32'h7, EPO_RESP_OKAY);
    wr(8'h0C, 32'hFFFFFFFF, 4'hF, EPO_RESP_SLVERR);
    reg_chk(8'h0C, 32'h0, EPO_RESP_SLVERR);
    wr(`EPO_ADDR_STATUS, 32'hFFFFFFFF, 4'hF, EPO_RESP_OKAY);
    reg_chk(`EPO_ADDR_LF_COUNT, 32'h0, EPO_RESP_OKAY);
    // rate ratio for every mode except the high-frequency one
    set_pw(24'sh010000);
    for (int i = 0; i < 7; i++) begin
      set_ctrl(CODES[i]);
      wait_lf(4);
      check_word(32'(ratio), 32'h1 << SH[i], "calibration per energy");
    end
    // 1024-cycle energy period keeps fixed width; 16-cycle calibration halves
    set_ctrl(3'h0);
    wait_lf(2);
    check_word(32'(lf_w), 32'(LF_W), "energy width");
    wait_cal(3);
    check_word(32'(cal_w), 32'h8, "calibration width");
    check_word(32'(rev), 32'h0, "reverse flag");
    set_pw(24'sh004000);
    wait_cal(3);
    check_word(32'(cal_w), 32'(CF_W), "calibration width");
    // just under the creep level, negative sign must not reach the flag
    set_pw(24'shFFFF34);
    repeat (5) @(negedge sys_clk);
    n0 = int'(lf_n);
    repeat (300) @(negedge sys_clk);
    check_word(32'(lf_n), 32'(n0), "energy count frozen");
    check_word(32'(cal), 32'h1, "calibration held");
    check_word(32'(rev), 32'h0, "reverse flag");
    reg_chk(`EPO_ADDR_STATUS, 32'h12, EPO_RESP_OKAY);
    reg_chk(`EPO_ADDR_LF_COUNT, 32'(lf_n), EPO_RESP_OKAY);
    // first magnitude at the creep level leaves no-load
    set_pw(24'sh0000CD);
    repeat (3) @(negedge sys_clk);
    rd_reg(`EPO_ADDR_STATUS, EPO_RESP_OKAY);
    check_word(rd & 32'h2, 32'h0, "no-load cleared");
    set_pw(24'shFF0000);
    wait_cal(2);
    check_word(32'(rev), 32'h1, "reverse flag");
    set_pw(24'sh010000);
    wait_cal(2);
    check_word(32'(rev), 32'h0, "reverse flag");
    // high-frequency mode: 16-cycle period, halving would show lows
    set_pw(24'sh000100);
    set_ctrl(3'h3);
    repeat (400) @(negedge sys_clk);
    n0 = 0;
    repeat (300) begin
      @(negedge sys_clk);
      if (cal !== 1'h1) n0++;
    end
    check_word(32'(n0), 32'h0, "fixed wide calibration");
    // 32-cycle energy period halves the energy width; calibration is 1 cycle high in every 2,
    // a faster load would saturate the calibration train into a steady high
    set_ctrl(3'h7);
    set_pw(24'sh040000);
    wait_lf(6);
    check_word(32'(lf_w), 32'h10, "energy width");
    check_word(32'(alt_n), 32'h0, "alternation");
    stop_test();
  end
endmodule // epo_pulse_stage_bench
